// >>> wir_consts.svh
// Constants for the wake-up interval RTC counter: offsets, fields, resets, counts.
// Assumes a 32-bit APB master and a free-running 32.768 kHz crystal clock input.
//
// Overview of operation
// - Sub-second counts 0..127 each 1/128 s
// - Seconds count 0..59, carry into minutes
// - Minutes count 0..59, carry into hours
// - Hours count 0..23 then wrap
// - Select field picks interval counter tick
// - Counter equal to target sets match flag
// - Match flag stays until software clears
// - Enabled flag requests interrupt, wakes power-down
// - One-shot timeout clears interval count enable
// - Auto-reload restarts counting at each timeout
// - Enable runs counter; disable clears it
// - Clock enable low clears prescaler; falling enable clears time
// - Time writes accepted only while clock disabled
// - Enabled clock keeps time across reset
// - Power cycle, or reset while disabled, clears
// - Target holds 0..255, zero on reset
// - Chain runs from crystal, not PLL
`ifndef WIR_CONSTS_SVH
`define WIR_CONSTS_SVH

// Register indices; byte address is four times the index
`define WIR_IDX_SUBSEC   8'ha2
`define WIR_IDX_SEC      8'ha3
`define WIR_IDX_MIN      8'ha4
`define WIR_IDX_HOUR     8'ha5
`define WIR_IDX_TARGET   8'ha6
`define WIR_IDX_CTRL     8'ha7

// Control register fields
`define WIR_F_TIMEBASE_CLOCK_ENABLE       0
`define WIR_F_ICE        1
`define WIR_F_FLAG       2
`define WIR_F_ONESHOT    3
`define WIR_F_TSEL_LO    4
`define WIR_F_TSEL_HI    5
`define WIR_F_RSV6       6

`define WIR_RST_BYTE     8'h00
`define WIR_PRE_MAX      8'hff
`define WIR_SUBSEC_MAX   8'h7f
`define WIR_SEC_MAX      8'h3b
`define WIR_MIN_MAX      8'h3b
`define WIR_HOUR_MAX     8'h17
`define WIR_WAKE_VECTOR  16'h0053

`endif

// >>> wir_pkg.sv
// Types for the wake-up interval RTC counter.
// Assumes wir_consts.svh supplies every number.
package wir_pkg;

	// State that survives a warm reset while the time clock runs
	typedef struct packed {
		logic [2:0] xsync;
		logic [1:0] rsync;
		logic [7:0] pre;
		logic [7:0] subsec;
		logic [7:0] sec;
		logic [7:0] mins;
		logic [7:0] hour;
		logic       timebase_clock_enable;
	} wir_keep_t;

	// State cleared by every reset
	typedef struct packed {
		logic [7:0]  target;
		logic [7:0]  icnt;
		logic [1:0]  tsel;
		logic        oneshot;
		logic        flag;
		logic        ice;
		logic        rsv6;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
		logic        irq;
		logic        wake;
	} wir_core_t;

	typedef enum logic [2:0] {
		WIR_SEL_NONE,
		WIR_SEL_SUBSEC,
		WIR_SEL_SEC,
		WIR_SEL_MIN,
		WIR_SEL_HOUR,
		WIR_SEL_TARGET,
		WIR_SEL_CTRL
	} wir_sel_t;

endpackage : wir_pkg

// >>> wir_top.sv
// Wake-up interval RTC counter: time chain, interval counter and APB slave.
// Assumes an APB master on pclk, a crystal clock sampled as a plain input,
// and an interrupt controller that consumes irq and wake.
`timescale 1ns/1ps
`default_nettype none
`include "wir_consts.svh"

module wir_top
	import wir_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	// Clock and resets
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              por_n,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output var  logic [31:0]       prdata,
	output var  logic              pready,
	output var  logic              pslverr,
	// Crystal and power state
	input  wire logic              xtal_clk_in,
	input  wire logic              power_down,
	input  wire logic              secondary_interrupt_enable,
	// Event outputs
	output var  logic              irq,
	output var  logic              wake
);

	////////////////////////////////////////////////////////////////////////////////
	// State

	wir_keep_t k_q;
	wir_keep_t k_d;
	wir_core_t c_q;
	wir_core_t c_d;

	wir_sel_t   rsel;
	wir_sel_t   sel;
	logic       setup;
	logic       wr_en;
	logic [7:0] wbyte;
	logic       xedge;
	logic [3:0] tick;
	logic       itick;
	logic [7:0] inext;
	logic [7:0] ctrl_rd;
	logic [7:0] rbyte;

	////////////////////////////////////////////////////////////////////////////////
	// Address decode

	always_comb begin
		rsel = WIR_SEL_NONE;
		if (paddr[1:0] == 2'h0) begin
			case (paddr[ADDR_W-1:2])
				(ADDR_W-2)'(`WIR_IDX_SUBSEC): rsel = WIR_SEL_SUBSEC;
				(ADDR_W-2)'(`WIR_IDX_SEC):    rsel = WIR_SEL_SEC;
				(ADDR_W-2)'(`WIR_IDX_MIN):    rsel = WIR_SEL_MIN;
				(ADDR_W-2)'(`WIR_IDX_HOUR):   rsel = WIR_SEL_HOUR;
				(ADDR_W-2)'(`WIR_IDX_TARGET): rsel = WIR_SEL_TARGET;
				(ADDR_W-2)'(`WIR_IDX_CTRL):   rsel = WIR_SEL_CTRL;
				default:                      rsel = WIR_SEL_NONE;
			endcase
		end
	end

	assign sel   = rsel;
	assign setup = psel & ~penable;
	// A write lands in the access cycle that sees our registered pready
	assign wr_en = psel & penable & pwrite & c_q.pready & ~c_q.pslverr;
	assign wbyte = pwdata[7:0];

	////////////////////////////////////////////////////////////////////////////////
	// Ticks from the retained chain

	// Only the second and third sync stages are looked at
	assign xedge = k_q.xsync[1] & ~k_q.xsync[2];

	always_comb begin
		tick    = 4'h0;
		tick[0] = k_q.timebase_clock_enable & xedge & (k_q.pre == `WIR_PRE_MAX);
		tick[1] = tick[0] & (k_q.subsec == `WIR_SUBSEC_MAX);
		tick[2] = tick[1] & (k_q.sec == `WIR_SEC_MAX);
		tick[3] = tick[2] & (k_q.mins == `WIR_MIN_MAX);
	end

	assign itick = tick[c_q.tsel];

	////////////////////////////////////////////////////////////////////////////////
	// Retained time chain

	always_comb begin
		k_d = k_q;
		k_d.xsync = {k_q.xsync[1:0], xtal_clk_in};
		k_d.rsync = {k_q.rsync[0], presetn};
		// Counting runs off crystal edges, so it keeps going in power-down
		if (k_q.timebase_clock_enable && xedge) begin
			k_d.pre = k_q.pre + 8'h01;
		end
		if (tick[0]) begin
			k_d.subsec = (k_q.subsec == `WIR_SUBSEC_MAX) ? `WIR_RST_BYTE
				: k_q.subsec + 8'h01;
		end
		if (tick[1]) begin
			k_d.sec = (k_q.sec == `WIR_SEC_MAX) ? `WIR_RST_BYTE
				: k_q.sec + 8'h01;
		end
		if (tick[2]) begin
			k_d.mins = (k_q.mins == `WIR_MIN_MAX) ? `WIR_RST_BYTE
				: k_q.mins + 8'h01;
		end
		if (tick[3]) begin
			k_d.hour = (k_q.hour == `WIR_HOUR_MAX) ? `WIR_RST_BYTE
				: k_q.hour + 8'h01;
		end
		if (!k_q.timebase_clock_enable) begin
			k_d.pre = `WIR_RST_BYTE;
		end
		// Time writes are dropped while the clock runs
		if (wr_en && !k_q.timebase_clock_enable) begin
			case (sel)
				WIR_SEL_SUBSEC: k_d.subsec = wbyte;
				WIR_SEL_SEC:    k_d.sec    = wbyte;
				WIR_SEL_MIN:    k_d.mins   = wbyte;
				WIR_SEL_HOUR:   k_d.hour   = wbyte;
				default:        k_d.timebase_clock_enable   = k_q.timebase_clock_enable;
			endcase
		end
		if (wr_en && sel == WIR_SEL_CTRL) begin
			k_d.timebase_clock_enable = wbyte[`WIR_F_TIMEBASE_CLOCK_ENABLE];
			// Falling enable clears once, so later time writes stick
			if (k_q.timebase_clock_enable && !wbyte[`WIR_F_TIMEBASE_CLOCK_ENABLE]) begin
				k_d.pre    = `WIR_RST_BYTE;
				k_d.subsec = `WIR_RST_BYTE;
				k_d.sec    = `WIR_RST_BYTE;
				k_d.mins   = `WIR_RST_BYTE;
				k_d.hour   = `WIR_RST_BYTE;
			end
		end
		// Warm reset wipes time only when the clock was off
		if (!k_q.rsync[1] && !k_q.timebase_clock_enable) begin
			k_d.pre    = `WIR_RST_BYTE;
			k_d.subsec = `WIR_RST_BYTE;
			k_d.sec    = `WIR_RST_BYTE;
			k_d.mins   = `WIR_RST_BYTE;
			k_d.hour   = `WIR_RST_BYTE;
			k_d.timebase_clock_enable   = 1'b0;
		end
	end

	// Only power-on resets these; warm reset is seen synchronously above
	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			k_q <= '0;
		end else begin
			k_q <= k_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interval counter, control and bus

	assign inext = c_q.icnt + 8'h01;

	always_comb begin
		ctrl_rd                 = 8'h00;
		ctrl_rd[`WIR_F_TIMEBASE_CLOCK_ENABLE]    = k_q.timebase_clock_enable;
		ctrl_rd[`WIR_F_ICE]     = c_q.ice;
		ctrl_rd[`WIR_F_FLAG]    = c_q.flag;
		ctrl_rd[`WIR_F_ONESHOT] = c_q.oneshot;
		ctrl_rd[`WIR_F_TSEL_LO] = c_q.tsel[0];
		ctrl_rd[`WIR_F_TSEL_HI] = c_q.tsel[1];
		ctrl_rd[`WIR_F_RSV6]    = c_q.rsv6;
	end

	always_comb begin
		case (sel)
			WIR_SEL_SUBSEC: rbyte = k_q.subsec;
			WIR_SEL_SEC:    rbyte = k_q.sec;
			WIR_SEL_MIN:    rbyte = k_q.mins;
			WIR_SEL_HOUR:   rbyte = k_q.hour;
			WIR_SEL_TARGET: rbyte = c_q.target;
			WIR_SEL_CTRL:   rbyte = ctrl_rd;
			default:        rbyte = 8'h00;
		endcase
	end

	always_comb begin
		c_d = c_q;
		// Zero-wait slave: answer prepared in setup, dropped after access
		c_d.pready  = setup;
		c_d.pslverr = setup & (sel == WIR_SEL_NONE);
		if (setup) begin
			c_d.prdata = {24'h000000, rbyte};
		end

		// Interval counter
		if (!c_q.ice) begin
			c_d.icnt = 8'h00;
		end else if (itick) begin
			c_d.icnt = inext;
			if (inext == c_q.target) begin
				c_d.flag = 1'b1;
				c_d.icnt = 8'h00;
				if (c_q.oneshot) begin
					c_d.ice = 1'b0;
				end else begin
					c_d.ice = 1'b1;
				end
			end
		end

		if (wr_en) begin
			case (sel)
				WIR_SEL_TARGET: c_d.target = wbyte;
				WIR_SEL_CTRL: begin
					c_d.rsv6    = wbyte[`WIR_F_RSV6];
					c_d.tsel    = {wbyte[`WIR_F_TSEL_HI], wbyte[`WIR_F_TSEL_LO]};
					c_d.oneshot = wbyte[`WIR_F_ONESHOT];
					c_d.ice     = wbyte[`WIR_F_ICE];
					// Writing zero clears; a match in the same cycle still sets
					if (!wbyte[`WIR_F_FLAG]) begin
						c_d.flag = (c_q.ice & itick & (inext == c_q.target));
					end
				end
				default: c_d.rsv6 = c_q.rsv6;
			endcase
		end

		c_d.irq  = c_d.flag & secondary_interrupt_enable;
		c_d.wake = c_d.flag & secondary_interrupt_enable & power_down;
	end

	// Power-on must clear these too, even if the warm reset pin is not pulsed
	always_ff @(posedge pclk or negedge presetn or negedge por_n) begin
		if (!presetn || !por_n) begin
			c_q <= '0;
		end else begin
			c_q <= c_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign prdata  = c_q.prdata;
	assign pready  = c_q.pready;
	assign pslverr = c_q.pslverr;
	assign irq     = c_q.irq;
	assign wake    = c_q.wake;

endmodule : wir_top

`default_nettype wire

// >>> wir_chk.sv
// Port checker for the wake-up interval RTC counter.
// Assumes the APB and event ports of wir_top; bound below.
`timescale 1ns/1ps
`default_nettype none
`include "wir_consts.svh"
module wir_chk #(
	parameter int ADDR_W = 12
) (
	// Watched ports
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic              power_down,
	input wire logic              secondary_interrupt_enable,
	input wire logic              irq,
	input wire logic              wake
);
	localparam logic [ADDR_W-1:0] CTRL = ADDR_W'(`WIR_IDX_CTRL) << 2;
	logic wr_ctrl;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	assign wr_ctrl = psel && penable && pwrite && paddr == CTRL;
	sequence setup_s; psel && !penable; endsequence
	sequence odd_s; setup_s ##0 paddr[1:0] != 2'h0; endsequence
	////////////////////////////////////////////////////////////////
	rdy_setup_a: assert property (setup_s |=> pready) else $error("no answer");
	rdy_pulse_a: assert property (pready |=> !pready) else $error("long pready");
	err_zero_a: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad err");
	odd_err_a: assert property (odd_s |=> pslverr) else $error("misaligned ok");
	high_zero_a: assert property (pready |-> prdata[31:8] == 24'h0) else $error("high bits");
	irq_en_a: assert property (irq |-> $past(secondary_interrupt_enable)) else $error("irq");
	wake_pd_a: assert property (wake |-> irq && $past(power_down)) else $error("wake");
	// The flag only drops after a control write; the enable only masks it
	flag_hold_a: assert property ($fell(irq) |-> $past(wr_ctrl, 2) || $past(wr_ctrl)
		|| !$past(secondary_interrupt_enable) || !$past(secondary_interrupt_enable, 2))
		else $error("flag lost");
endmodule : wir_chk
bind wir_top wir_chk #(.ADDR_W(ADDR_W)) chk_i (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .power_down(power_down), .irq(irq), .wake(wake),
	.secondary_interrupt_enable(secondary_interrupt_enable));
`default_nettype wire

// >>> test_wir_top.sv
// Testbench for the wake-up interval RTC counter.
// Assumes wir_top; the crystal stands in at one eighth of pclk.
`timescale 1ns/1ps
`default_nettype none
`include "wir_consts.svh"
module test_wir_top;
	typedef struct packed {logic [7:0] i, w, r; logic e;} wir_row_t;
	logic        pclk, presetn, por_n, psel, penable, pwrite, pd, sie;
	logic        pready, pslverr, irq, wake, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [2:0]  xc;
	int          err_count, checks, n;
	time         t1;
	wir_row_t    rows [5];
	wir_top dut (.pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .xtal_clk_in(xc[2]),
		.power_down(pd), .secondary_interrupt_enable(sie), .irq(irq), .wake(wake));
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	// 256 crystal edges of 8 pclk each: one sub-second tick per 2048 cycles
	always @(posedge pclk) xc <= por_n ? xc + 3'h1 : 3'h0;
	////////////////////////////////////////////////////////////////
	function automatic logic [11:0] ba(input logic [7:0] i);
		return {2'h0, i, 2'h0};
	endfunction : ba
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			err_count++;
			$display("[FAIL] %0t saw %h want %h", $time, s, e);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rdc(input logic [7:0] i, input logic [31:0] e);
		apb(1'b0, ba(i), 32'h0);
		chk(rd, e);
	endtask : rdc
	task automatic wait_irq(input int lim);
		n = 0;
		while (irq !== 1'b1 && n < lim) begin
			@(posedge pclk);
			n++;
		end
	endtask : wait_irq
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : test_done
	////////////////////////////////////////////////////////////////
	initial begin
		#(40000 * 50);
		err_count++;
		test_done;
	end
	initial begin
		{presetn, por_n, psel, penable, pwrite, pd, sie} = 7'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		rows[0] = '{8'ha6, 8'hff, 8'hff, 1'b0};
		rows[1] = '{8'ha6, 8'h5a, 8'h5a, 1'b0};
		rows[2] = '{8'ha7, 8'hc0, 8'h40, 1'b0};
		rows[3] = '{8'ha3, 8'h3b, 8'h3b, 1'b0};
		rows[4] = '{8'ha8, 8'h12, 8'h00, 1'b1};
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		por_n <= 1'b1;
		for (int i = 0; i < 6; i++) rdc(8'ha2 + 8'(i), 32'h0);
		$display("reset values done");
		foreach (rows[k]) begin
			apb(1'b1, ba(rows[k].i), {24'h0, rows[k].w});
			rdc(rows[k].i, {24'h0, rows[k].r});
			chk({31'h0, er}, {31'h0, rows[k].e});
		end
		apb(1'b0, ba(`WIR_IDX_TARGET) | 12'h1, 32'h0);
		chk({31'h0, er}, 32'h1);
		$display("register table done");
		apb(1'b1, ba(`WIR_IDX_SUBSEC), 32'h7f);
		apb(1'b1, ba(`WIR_IDX_MIN), 32'h3b);
		apb(1'b1, ba(`WIR_IDX_HOUR), 32'h17);
		apb(1'b1, ba(`WIR_IDX_CTRL), 32'h41);
		apb(1'b1, ba(`WIR_IDX_SEC), 32'h05);
		repeat (2200) @(posedge pclk);
		for (int i = 0; i < 4; i++) rdc(8'ha2 + 8'(i), 32'h0);
		$display("time wrap done");
		sie <= 1'b1;
		pd <= 1'b1;
		apb(1'b1, ba(`WIR_IDX_TARGET), 32'h02);
		apb(1'b1, ba(`WIR_IDX_CTRL), 32'h4b);
		n = 0;
		while (irq !== 1'b1 && n < 6000) begin
			@(posedge pclk);
			n++;
		end
		chk(32'(n > 2048 && n < 4200), 32'h1);
		chk({31'h0, wake}, 32'h1);
		rdc(`WIR_IDX_CTRL, 32'h4d);
		apb(1'b1, ba(`WIR_IDX_CTRL), 32'h49);
		rdc(`WIR_IDX_CTRL, 32'h49);
		chk({31'h0, irq}, 32'h0);
		$display("one-shot interval done");
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rdc(`WIR_IDX_CTRL, 32'h01);
		rdc(`WIR_IDX_TARGET, 32'h00);
		$display("warm reset done");
		pd <= 1'b0;
		apb(1'b1, ba(`WIR_IDX_TARGET), 32'h01);
		apb(1'b1, ba(`WIR_IDX_CTRL), 32'h43);
		wait_irq(2200);
		t1 = $time;
		chk({31'h0, wake}, 32'h0);
		apb(1'b1, ba(`WIR_IDX_CTRL), 32'h43);
		rdc(`WIR_IDX_CTRL, 32'h43);
		wait_irq(2200);
		chk(32'(($time - t1) / 50), 32'd2048);
		t1 = $time;
		apb(1'b1, ba(`WIR_IDX_TARGET), 32'h02);
		repeat (2100) @(posedge pclk);
		apb(1'b1, ba(`WIR_IDX_CTRL), 32'h41);
		repeat (700) @(posedge pclk);
		apb(1'b1, ba(`WIR_IDX_CTRL), 32'h43);
		wait_irq(4000);
		chk(32'(($time - t1) / 50), 32'd6144);
		sie <= 1'b0;
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h0);
		rdc(`WIR_IDX_CTRL, 32'h47);
		$display("auto-reload done");
		apb(1'b1, ba(`WIR_IDX_CTRL), 32'h40);
		rdc(`WIR_IDX_SUBSEC, 32'h0);
		apb(1'b1, ba(`WIR_IDX_SUBSEC), 32'h11);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rdc(`WIR_IDX_SUBSEC, 32'h0);
		sie <= 1'b1;
		apb(1'b1, ba(`WIR_IDX_TARGET), 32'h01);
		for (int s = 1; s < 4; s++) begin
			apb(1'b1, ba(`WIR_IDX_CTRL), 32'h40);
			apb(1'b1, ba(`WIR_IDX_SUBSEC), 32'h7f);
			apb(1'b1, ba(`WIR_IDX_SEC), 32'h3b);
			apb(1'b1, ba(`WIR_IDX_MIN), 32'h3a);
			apb(1'b1, ba(`WIR_IDX_CTRL), 32'h4b | 32'(s << 4));
			repeat (2200) @(posedge pclk);
			chk({31'h0, irq}, {31'h0, s != 3});
		end
		$display("timebase select done");
		test_done;
	end
endmodule : test_wir_top
`default_nettype wire
